// ### shared/pbt_map.svh
// Constants of the programmable binary timer: register map, taps, timing.
// Assumes a 40 MHz mclk; included by the timer core.
`ifndef PBT_MAP_SVH
`define PBT_MAP_SVH

// Clock rate and derived timing
`define PBT_CLK_MHZ        40
`define PBT_POR_TIME_NS    1000
`define PBT_POR_CYCLES     ((`PBT_POR_TIME_NS * `PBT_CLK_MHZ + 999) / 1000)
`define PBT_RC_HALF_NS     5000
`define PBT_RC_HALF_CYCLES ((`PBT_RC_HALF_NS * `PBT_CLK_MHZ) / 1000)

// Register indices on the plain port
`define PBT_ADDR_STATUS    4'h0
`define PBT_ADDR_MASK      4'h1
`define PBT_ADDR_COUNT     4'h2
`define PBT_ADDR_STATE     4'h3

// Status and mask bit positions
`define PBT_EV_DONE        0
`define PBT_EV_TAP         1
`define PBT_EV_RELEASE     2

// Tap bit index for each stage count
`define PBT_TAP_2P8        7
`define PBT_TAP_2P10       9
`define PBT_TAP_2P13       12
`define PBT_TAP_2P16       15

// Increments and reset values
`define PBT_STEP_NORMAL    16'h0001
`define PBT_STEP_BYPASS    16'h0100
`define PBT_ZERO16         16'h0000
`define PBT_ZERO3          3'h0
`define PBT_ZERO12         12'h000

`endif

// ### shared/pbt_pkg.sv
// Types shared by the programmable binary timer.
// Holds no constants; numeric values live in pbt_map.svh.
package pbt_pkg;

	// Single-cycle latch control: cleared, counting, latch set
	typedef enum logic [2:0] {
		PBT_CLEAR = 3'b001,
		PBT_RUN   = 3'b010,
		PBT_DONE  = 3'b100
	} pbt_state_t;

endpackage

// ### design/pbt_timer.sv
// Programmable binary timer core: 16-stage counter, tap select, output logic,
// oscillator model, automatic and forced clear, register port and interrupt.
// Assumes all pin inputs are synchronous to mclk and the clock runs at 40 MHz.
//
// Summary of operation
// - Inhibit low: clear counter at power-up
// - Forced clear high holds counter cleared
// - Any clear resets all stages together
// - Inhibit high disables automatic power-up clear
// - Two select bits choose one tap
// - High select one picks sixteenth stage
// - Low select zero with high select one bypasses first eight stages
// - Output equals level select during clear
// - Recycle mode passes tap to output
// - Single mode: latch sets after half count
// - Single mode holds output after toggle
// - Clear pulse or mode change re-arms
// - External clock overrides internal oscillator
// - Oscillator stops while any clear active
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pbt_map.svh"

module pbt_timer (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        oscillatorInput,
	input  wire logic        extClockSelect,
	input  wire logic        powerOnClearInhibit,
	input  wire logic        forcedClear,
	input  wire logic        outLevelSel,
	input  wire logic        modeSel,
	input  wire logic        selA,
	input  wire logic        selB,
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [15:0] regRdata,
	output logic             timerOut,
	output logic             oscRun,
	output logic             irq
);

	// Power-on clear state
	logic                porActive_reg;
	logic                porActive_next;
	logic [11:0]         porCnt_reg;
	logic [11:0]         porCnt_next;
	// Oscillator model and edge detect
	logic [11:0]         rcDiv_reg;
	logic [11:0]         rcDiv_next;
	logic                rcPhase_reg;
	logic                rcPhase_next;
	logic                oscInPrev_reg;
	logic                oscInPrev_next;
	logic                oscRun_reg;
	logic                oscRun_next;
	// Counter and output
	logic [15:0]         cnt_reg;
	logic [15:0]         cnt_next;
	logic                modePrev_reg;
	logic                modePrev_next;
	logic                timerOut_reg;
	logic                timerOut_next;
	logic                clearPrev_reg;
	logic                clearPrev_next;
	pbt_pkg::pbt_state_t state_reg;
	pbt_pkg::pbt_state_t state_next;
	// Registers
	logic [2:0]          status_reg;
	logic [2:0]          status_next;
	logic [2:0]          mask_reg;
	logic [2:0]          mask_next;
	logic [15:0]         rdata_reg;
	logic [15:0]         rdata_next;
	// Combinational helpers
	logic                modeChange;
	logic                clearActive;
	logic                intTick;
	logic                extTick;
	logic                tick;
	logic                bypass;
	logic                tapNow;
	logic                tapNext;
	logic [2:0]          events;

	// Clear sources: power-up, pin, or a change of mode level
	assign modeChange  = modeSel != modePrev_reg;
	assign clearActive = porActive_reg | forcedClear | modeChange;

	// Power-up clear runs a fixed time unless inhibited for low power
	always_comb begin
		porActive_next = porActive_reg;
		porCnt_next    = porCnt_reg;
		if (powerOnClearInhibit) begin
			porActive_next = 1'h0;
		end else if (porActive_reg) begin
			if (porCnt_reg == 12'(`PBT_POR_CYCLES - 1)) begin
				porActive_next = 1'h0;
			end else begin
				porCnt_next = porCnt_reg + 12'h001;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			porActive_reg <= 1'h1;
			porCnt_reg    <= `PBT_ZERO12;
		end else begin
			porActive_reg <= porActive_next;
			porCnt_reg    <= porCnt_next;
		end
	end

	// Internal oscillator is held at its reset phase and count during clear to save power
	always_comb begin
		rcDiv_next     = rcDiv_reg;
		rcPhase_next   = rcPhase_reg;
		oscInPrev_next = oscillatorInput;
		oscRun_next    = !clearActive;
		if (clearActive) begin
			rcDiv_next   = `PBT_ZERO12;
			rcPhase_next = 1'h0;
		end else if (rcDiv_reg == 12'(`PBT_RC_HALF_CYCLES - 1)) begin
			rcDiv_next   = `PBT_ZERO12;
			rcPhase_next = !rcPhase_reg;
		end else begin
			rcDiv_next = rcDiv_reg + 12'h001;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rcDiv_reg     <= `PBT_ZERO12;
			rcPhase_reg   <= 1'h0;
			oscInPrev_reg <= 1'h0;
			oscRun_reg    <= 1'h0;
		end else begin
			rcDiv_reg     <= rcDiv_next;
			rcPhase_reg   <= rcPhase_next;
			oscInPrev_reg <= oscInPrev_next;
			oscRun_reg    <= oscRun_next;
		end
	end

	// Rising edges only; the external pin replaces the RC source outright
	assign intTick = !rcPhase_reg && rcPhase_next;
	assign extTick = oscillatorInput && !oscInPrev_reg;
	assign tick    = !clearActive && (extClockSelect ? extTick : intTick);

	// Low select zero with high select one feeds stage nine directly
	assign bypass = selA && !selB;

	// Tap from the present count and from the next count
	always_comb begin
		case ({selA, selB})
			2'b00: begin
				tapNow  = cnt_reg[`PBT_TAP_2P13];
				tapNext = cnt_next[`PBT_TAP_2P13];
			end
			2'b01: begin
				tapNow  = cnt_reg[`PBT_TAP_2P10];
				tapNext = cnt_next[`PBT_TAP_2P10];
			end
			default: begin
				tapNow  = cnt_reg[`PBT_TAP_2P16];
				tapNext = cnt_next[`PBT_TAP_2P16];
			end
		endcase
	end

	// Counter, latch state and output level
	always_comb begin
		cnt_next       = cnt_reg;
		state_next     = state_reg;
		modePrev_next  = modeSel;
		clearPrev_next = clearActive;
		if (clearActive) begin
			cnt_next = `PBT_ZERO16;
		end else if (tick) begin
			cnt_next = cnt_reg + (bypass ? `PBT_STEP_BYPASS : `PBT_STEP_NORMAL);
		end
		case (state_reg)
			pbt_pkg::PBT_CLEAR: begin
				if (!clearActive) begin
					state_next = pbt_pkg::PBT_RUN;
				end
			end
			pbt_pkg::PBT_RUN: begin
				if (clearActive) begin
					state_next = pbt_pkg::PBT_CLEAR;
				end else if (!modeSel && tapNow) begin
					state_next = pbt_pkg::PBT_DONE;
				end
			end
			pbt_pkg::PBT_DONE: begin
				if (clearActive) begin
					state_next = pbt_pkg::PBT_CLEAR;
				end
			end
			default: begin
				state_next = pbt_pkg::PBT_CLEAR;
			end
		endcase
		// Level select flips the sense; during clear both terms are zero
		if (modeSel) begin
			timerOut_next = outLevelSel ^ tapNext;
		end else begin
			timerOut_next = outLevelSel ^ (state_next == pbt_pkg::PBT_DONE);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg       <= `PBT_ZERO16;
			state_reg     <= pbt_pkg::PBT_CLEAR;
			modePrev_reg  <= 1'h0;
			clearPrev_reg <= 1'h1;
			timerOut_reg  <= 1'h0;
		end else begin
			cnt_reg       <= cnt_next;
			state_reg     <= state_next;
			modePrev_reg  <= modePrev_next;
			clearPrev_reg <= clearPrev_next;
			timerOut_reg  <= timerOut_next;
		end
	end

	// Events: latch set, recycle tap rise, clear released
	always_comb begin
		events                  = `PBT_ZERO3;
		events[`PBT_EV_DONE]    = state_reg == pbt_pkg::PBT_RUN && state_next == pbt_pkg::PBT_DONE;
		events[`PBT_EV_TAP]     = modeSel && !clearActive && !tapNow && tapNext;
		events[`PBT_EV_RELEASE] = clearPrev_reg && !clearActive;
	end

	// Register port; a new event beats a write-one-to-clear in the same cycle
	always_comb begin
		status_next = status_reg;
		mask_next   = mask_reg;
		rdata_next  = `PBT_ZERO16;
		if (regWrite && regAddr == `PBT_ADDR_STATUS) begin
			status_next = status_reg & ~regWdata[2:0];
		end
		if (regWrite && regAddr == `PBT_ADDR_MASK) begin
			mask_next = regWdata[2:0];
		end
		status_next = status_next | events;
		if (regRead) begin
			case (regAddr)
				`PBT_ADDR_STATUS: rdata_next = {13'h0000, status_reg};
				`PBT_ADDR_MASK:   rdata_next = {13'h0000, mask_reg};
				`PBT_ADDR_COUNT:  rdata_next = cnt_reg;
				`PBT_ADDR_STATE:  rdata_next = {11'h000, timerOut_reg, oscRun_reg,
					state_reg == pbt_pkg::PBT_DONE, porActive_reg, clearActive};
				default:          rdata_next = `PBT_ZERO16;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= `PBT_ZERO3;
			mask_reg   <= `PBT_ZERO3;
			rdata_reg  <= `PBT_ZERO16;
		end else begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
			rdata_reg  <= rdata_next;
		end
	end

	// Outputs
	assign regRdata = rdata_reg;
	assign timerOut = timerOut_reg;
	assign oscRun   = oscRun_reg;
	assign irq      = |(status_reg & mask_reg);

	// Automatic clear zeroes the count while it runs
	a_por_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		porActive_reg && !powerOnClearInhibit |=> cnt_reg == `PBT_ZERO16)
		else $error("power-up clear left count nonzero");

	// Forced clear held for two cycles keeps the count at zero
	a_forced_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		forcedClear [*2] |-> cnt_reg == `PBT_ZERO16 && state_reg == pbt_pkg::PBT_CLEAR)
		else $error("forced clear did not hold counter");

	// Any clear zeroes every stage whatever the prior count
	a_clear_all: assert property (@(posedge mclk) disable iff (!rst_n)
		clearActive && cnt_reg != `PBT_ZERO16 |=> cnt_reg == `PBT_ZERO16)
		else $error("clear missed some stages");

	// Inhibit ends the automatic clear at once
	a_inhibit_por: assert property (@(posedge mclk) disable iff (!rst_n)
		powerOnClearInhibit |=> !porActive_reg)
		else $error("automatic clear ran while inhibited");

	// Sixteenth stage alone decides the latch for either low select value
	a_high_sel: assert property (@(posedge mclk) disable iff (!rst_n)
		selA && !modeSel && !clearActive && state_reg == pbt_pkg::PBT_RUN
		|=> (state_reg == pbt_pkg::PBT_DONE) == $past(cnt_reg[`PBT_TAP_2P16]))
		else $error("high select did not pick stage sixteen");

	// Bypass steps stage nine on each oscillator edge
	a_bypass_step: assert property (@(posedge mclk) disable iff (!rst_n)
		tick && bypass |=> cnt_reg == $past(cnt_reg) + `PBT_STEP_BYPASS)
		else $error("bypass step wrong");

	// Normal counting advances by one per edge
	a_count_step: assert property (@(posedge mclk) disable iff (!rst_n)
		tick && !bypass |=> cnt_reg == $past(cnt_reg) + `PBT_STEP_NORMAL)
		else $error("count step wrong");

	// Output shows the level select while cleared
	a_out_level: assert property (@(posedge mclk) disable iff (!rst_n)
		clearActive |=> timerOut_reg == $past(outLevelSel))
		else $error("output not at reset level during clear");

	// Recycle mode on the tenth stage follows that stage of the new count
	a_recycle_out: assert property (@(posedge mclk) disable iff (!rst_n)
		modeSel && !clearActive && !selA && selB
		|=> timerOut_reg == ($past(outLevelSel) ^ cnt_reg[`PBT_TAP_2P10]))
		else $error("recycle output does not follow tap");

	// Latch sets the cycle after the tap rises in single mode
	a_latch_set: assert property (@(posedge mclk) disable iff (!rst_n)
		state_reg == pbt_pkg::PBT_RUN && !modeSel && tapNow && !clearActive
		|=> state_reg == pbt_pkg::PBT_DONE)
		else $error("single-cycle latch failed to set");

	// Once set, latch and output hold until a clear
	a_single_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		state_reg == pbt_pkg::PBT_DONE && !clearActive && $stable(outLevelSel)
		|=> state_reg == pbt_pkg::PBT_DONE && $stable(timerOut_reg))
		else $error("single-cycle output changed again");

	// Mode change re-arms: latch back to cleared
	a_mode_rearm: assert property (@(posedge mclk) disable iff (!rst_n)
		modeChange |=> state_reg == pbt_pkg::PBT_CLEAR && cnt_reg == `PBT_ZERO16)
		else $error("mode change did not re-arm");

	// No count edge and oscillator flagged stopped during clear
	a_osc_stop: assert property (@(posedge mclk) disable iff (!rst_n)
		clearActive |-> !tick ##1 !oscRun_reg)
		else $error("oscillator ran during clear");

	// With the external clock selected, nothing but a pin edge moves the count
	a_ext_clock: assert property (@(posedge mclk) disable iff (!rst_n)
		extClockSelect && !clearActive && !(oscillatorInput && !oscInPrev_reg)
		|=> $stable(cnt_reg))
		else $error("count moved without an external clock edge");

endmodule

// ### sim/pbt_clock_source.sv
// External clock source that sits on the timer's oscillator input.
// Assumes the caller starts a burst just after a rising mclk edge.
`timescale 1ns/1ps
module pbt_clock_source (
	input  wire logic mclk,
	output logic      oscillatorInput
);
	// The line rests low between bursts, as a gated clock would
	initial oscillatorInput = 1'b0;

	// Each phase lasts at least one mclk cycle, so the core never misses an edge
	task automatic burst(input int n, input int hi, input int lo);
		repeat (n) begin
			oscillatorInput <= 1'b1;
			repeat (hi) @(posedge mclk);
			oscillatorInput <= 1'b0;
			repeat (lo) @(posedge mclk);
		end
	endtask
endmodule

// ### sim/programmable_binary_timer_test.sv
// Self-checking bench for the programmable binary timer core.
// Assumes the core and the clock source model are compiled before it.
`timescale 1ns/1ps
module programmable_binary_timer_test;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        oscIn;
	logic        extClockSelect = 1'b1;
	logic        powerOnClearInhibit = 1'b0;
	logic        forcedClear = 1'b0;
	logic        outLevelSel = 1'b1;
	logic        modeSel = 1'b0;
	logic        selA = 1'b0;
	logic        selB = 1'b1;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [15:0] regRdata;
	logic        timerOut;
	logic        oscRun;
	logic        irq;
	logic [15:0] last;
	int          fail_count = 0;
	int          total_checks = 0;
	int          half[4] = '{4096, 512, 128, 32768};
	logic [15:0] cnt[4] = '{16'h0FFF, 16'h01FF, 16'h7F00, 16'h7FFF};

	// 40 MHz system clock
	always #12.5 mclk = ~mclk;

	pbt_clock_source src (.mclk(mclk), .oscillatorInput(oscIn));

	pbt_timer uut (
		.mclk(mclk), .rst_n(rst_n), .oscillatorInput(oscIn),
		.extClockSelect(extClockSelect), .powerOnClearInhibit(powerOnClearInhibit),
		.forcedClear(forcedClear), .outLevelSel(outLevelSel), .modeSel(modeSel),
		.selA(selA), .selB(selB), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.timerOut(timerOut), .oscRun(oscRun), .irq(irq)
	);

	// Comparison of any result, counted and reported on mismatch
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic pc(input string what, input logic exp, input logic got);
		chk(what, {15'h0000, exp}, {15'h0000, got});
	endtask

	// Bus tasks begin on a fresh edge so no strobe is assigned twice in one step
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe edge
	task automatic rc(input string what, input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		last = regRdata;
		chk(what, exp, regRdata);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Two idle edges first, so a just-released clear has dropped before counting
	task automatic go(input int n);
		repeat (2) @(posedge mclk);
		src.burst(n, 1, 1);
		settle(3);
	endtask

	task automatic tally_and_finish();
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (90000) @(posedge mclk);
		fail_count++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		settle(2);
		pc("outInPor", 1'b1, timerOut);
		pc("oscRunInPor", 1'b0, oscRun);
		rc("stateInPor", 4'h3, 16'h0013);
		settle(50);
		pc("oscRunAfterPor", 1'b1, oscRun);
		rc("stateAfterPor", 4'h3, 16'h0018);
		pc("irqMaskedOff", 1'b0, irq);
		wr(4'h1, 16'h0001);
		rc("maskReg", 4'h1, 16'h0001);
		settle(1);
		chk("rdataIdle", 16'h0000, regRdata);
		wr(4'h7, 16'hFFFF);
		rc("unmapped", 4'h7, 16'h0000);
		rc("statusRelease", 4'h0, 16'h0004);
		wr(4'h0, 16'h0007);
		rc("statusClear", 4'h0, 16'h0000);
		@(posedge mclk);
		outLevelSel <= 1'b0;
		// One single-cycle run per tap code, re-armed by a forced clear each time
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			forcedClear <= 1'b1;
			{selA, selB} <= i[1:0];
			settle(3);
			pc("oscRunInClear", 1'b0, oscRun);
			pc("outInClear", 1'b0, timerOut);
			rc("countCleared", 4'h2, 16'h0000);
			@(posedge mclk);
			forcedClear <= 1'b0;
			go(half[i] - 1);
			rc("countBefore", 4'h2, cnt[i]);
			pc("outBefore", 1'b0, timerOut);
			go(1);
			pc("outToggled", 1'b1, timerOut);
			go(130);
			pc("outHeld", 1'b1, timerOut);
		end
		// Interrupt raised by the latch, then masked, unmasked and cleared
		pc("irqRaised", 1'b1, irq);
		wr(4'h1, 16'h0000);
		settle(2);
		pc("irqMasked", 1'b0, irq);
		wr(4'h1, 16'h0001);
		settle(2);
		pc("irqUnmasked", 1'b1, irq);
		wr(4'h0, 16'h0001);
		settle(2);
		pc("irqCleared", 1'b0, irq);
		// Recycle mode on the 2^10 tap; entering it clears the count
		@(posedge mclk);
		{selA, selB} <= 2'b01;
		modeSel <= 1'b1;
		settle(3);
		rc("countModeIn", 4'h2, 16'h0000);
		pc("outModeIn", 1'b0, timerOut);
		go(511);
		pc("divLow", 1'b0, timerOut);
		go(1);
		pc("divHigh", 1'b1, timerOut);
		go(512);
		pc("divLowAgain", 1'b0, timerOut);
		rc("statusTap", 4'h0, 16'h0006);
		@(posedge mclk);
		modeSel <= 1'b0;
		settle(3);
		rc("countModeOut", 4'h2, 16'h0000);
		// Internal oscillator counts only while the external clock is not selected
		@(posedge mclk);
		extClockSelect <= 1'b0;
		settle(850);
		// Two internal rising edges fit in 850 cycles at a 400-cycle period
		rc("countInternal", 4'h2, 16'h0002);
		pc("internalTicks", 1'b1, last != 16'h0000);
		@(posedge mclk);
		extClockSelect <= 1'b1;
		forcedClear <= 1'b1;
		settle(3);
		@(posedge mclk);
		forcedClear <= 1'b0;
		go(5);
		settle(850);
		rc("countExternal", 4'h2, 16'h0005);
		// Second reset with the power-up clear inhibited
		@(posedge mclk);
		powerOnClearInhibit <= 1'b1;
		rst_n <= 1'b0;
		settle(3);
		@(posedge mclk);
		rst_n <= 1'b1;
		settle(4);
		pc("oscRunNoPor", 1'b1, oscRun);
		rc("stateNoPor", 4'h3, 16'h0008);
		tally_and_finish();
	end
endmodule
